// >>> seq_pkg.sv
// Purpose: Shared constants and types for the conditioning sequencer
// Assumes: 250 MHz system clock
// Notes:   Offsets are byte addresses on the AXI4-Lite register bus
package seq_pkg;

	// -------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS   = 4000;   // 4 ns clock
	localparam int unsigned START_WIN_MS    = 30;     // Start window length
	localparam int unsigned START_WIN_CYC   = START_WIN_MS * (1000000000 / CLK_PERIOD_PS);
	localparam int unsigned WDOG_CYC        = 1024;   // Loop watchdog limit
	localparam int unsigned OSC_CHK_CYC     = 256;    // Oscillator tick timeout

	// -------------------------------------------------------------
	// Register map
	// -------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;    // Configuration
	localparam logic [7:0] REG_STATUS = 8'h04;    // State and step
	localparam logic [7:0] REG_ERR    = 8'h08;    // Error flags, write 1 clear
	localparam logic [7:0] REG_CTEST  = 8'h0c;    // Transceiver test drive
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;

	// CTRL field positions
	localparam int CTRL_OUT_LSB  = 0;  // [1:0] output select
	localparam int CTRL_DIAG_EN  = 2;  // Diagnostic processing enable
	localparam int CTRL_BDC_EN   = 3;  // Broken die check enable
	localparam int CTRL_CTEST    = 4;  // Conformance test request
	localparam int CTRL_SLEEP_EN = 5;  // LIN sleep allowed

	// -------------------------------------------------------------
	// Types
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		OUT_LIN  = 2'b00,
		OUT_HIGH = 2'b01,
		OUT_LOW  = 2'b10
	} out_sel_t;

	typedef enum logic [2:0] {
		ST_POWERUP = 3'b000,
		ST_NVREAD  = 3'b001,
		ST_START   = 3'b010,
		ST_NORMAL  = 3'b011,
		ST_COMMAND = 3'b100,
		ST_DIAG    = 3'b101,
		ST_CTEST   = 3'b110
	} sys_state_t;

	// Multiplexer step codes
	typedef enum logic [3:0] {
		MX_BRIDGE_AZ = 4'h0,
		MX_CALT_AZ   = 4'h1,
		MX_CALT      = 4'h2,
		MX_TEMP_AZ   = 4'h3,
		MX_TEMP      = 4'h4,
		MX_AGING     = 4'h5,
		MX_CONN_POS  = 4'h6,
		MX_CONN_NEG  = 4'h7,
		MX_BRIDGE    = 4'h8
	} mux_step_t;

	typedef struct packed {
		logic osc;      // Oscillator failure
		logic wdog;     // Watchdog expiry
		logic mem;      // Memory/ALU self test
		logic sensor;   // Connection/short/aging
		logic die;      // Broken die
		logic sig;      // Signature mismatch
	} err_t;

	typedef struct packed {
		logic drv_en;   // Transceiver driver enable
		logic txd;      // Transmit data
		logic rx_en;    // Receiver enable
	} ctest_t;

endpackage

// >>> sensor_conditioning_sequencer.sv
// Purpose: Power-up sequencing, mode control and measurement mux stepping
// Assumes: Analog front end and math unit report completion by strobes
// Notes:   Registers reached over AXI4-Lite; one answer per access
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

// Notes on behaviour
// - Three main states: normal, command, diagnostic
// - After reset: nonvolatile read, signature check, start
// - Start window up to 30ms accepts entry frames
// - Window elapsed: normal state, cycle continuously
// - Fixed step order, bridge measurement after each
// - Start routine measures everything once first
// - Diagnostic steps always scheduled regardless of enable
// - Bridge result auto-zeroed, compensated, 15-bit positive
// - LIN temperature corrected, 15-bit positive
// - High-side pin uses inverted LIN levels
// - LIN pin accepted anytime in normal LIN operation
// - Drivers high impedance throughout start window
// - After window: PWM or LIN answering per configuration
// - Failure enters diagnostic; resistive PWM or LIN bits
// - Watchdog on loop, oscillator failure detector
// - Optional broken die check during start-up
// - Memory, register and ALU failures enter diagnostic
// - Conformance test drives transceiver controls separately
// - LIN cycle takes two temperature measurements
module sensor_conditioning_sequencer
	import seq_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	// AXI4-Lite slave
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	// Nonvolatile memory readout
	input  wire logic        i_nv_done,      // Readout finished pulse
	input  wire logic        i_nv_sig_ok,    // Signature matches
	// Front end / math unit
	input  wire logic        i_step_done,    // Current step finished pulse
	input  wire logic        i_die_fail,     // Broken die detected
	input  wire logic        i_sensor_fail,  // Connection/short/aging fault
	input  wire logic        i_selftest_fail,// Memory/register/ALU fault
	input  wire logic        i_calc_alive,   // Math unit heartbeat pulse
	input  wire logic        i_osc_tick,     // Oscillator monitor tick (async)
	// Link decoder
	input  wire logic        i_entry_frame,  // Valid entry frame pulse
	input  wire logic        i_lin_frame,    // LIN frame pulse in normal
	// Outputs
	output sys_state_t       o_state,
	output mux_step_t        o_mux_step,
	output logic             o_mux_start,    // Start step pulse
	output logic             o_drv_hiz,      // All drivers high impedance
	output logic             o_pwm_run,      // PWM generation active
	output logic             o_pwm_resistive,// PWM in resistive mode
	output logic             o_lin_respond,  // Answer LIN master
	output logic             o_high_invert,  // High-side pin inverts levels
	output err_t             o_lin_err,      // LIN status bits
	output ctest_t           o_ctest,        // Transceiver test drive
	output logic             o_lin_frame_ack // LIN frame taken in normal
);

	// -------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------
	sys_state_t  state;          // Main state
	sys_state_t  next_state;     // Next main state
	logic [31:0] ctrl;           // Configuration register
	ctest_t      ctest;          // Test drive register
	err_t        err;            // Sticky error flags
	err_t        err_clr;        // Write-one clear mask
	err_t        err_set;        // New events
	logic [23:0] win_cnt;        // Start window counter
	logic        win_done;       // Window elapsed
	logic [3:0]  phase;          // Cycle position, odd = bridge
	logic        first_pass;     // Start routine measurement pass
	logic [10:0] wdog_cnt;       // Loop watchdog
	logic [8:0]  osc_cnt;        // Oscillator tick watchdog
	logic        osc_s1;         // Sync stage 1
	logic        osc_s2;         // Sync stage 2
	logic        osc_s3;         // Edge detect history
	logic        aw_hold;        // Write address taken
	logic        w_hold;         // Write data taken
	logic [7:0]  aw_addr;        // Latched write address
	logic [31:0] w_data;         // Latched write data
	logic [3:0]  w_strb;         // Latched strobes
	logic        wr_go;          // Perform write
	out_sel_t    out_sel;        // Configured output
	logic        mux_start;      // Step start pulse

	assign out_sel  = out_sel_t'(ctrl[CTRL_OUT_LSB +: 2]);
	assign win_done = (win_cnt == 24'(START_WIN_CYC - 1));
	assign wr_go    = aw_hold && w_hold && !o_bvalid;

	// -------------------------------------------------------------
	// Main state machine
	// -------------------------------------------------------------
	// Next state from events; failures take priority
	always_comb begin
		next_state = state;
		unique case (state)
			ST_POWERUP: next_state = ST_NVREAD;
			ST_NVREAD: begin
				if (i_nv_done) begin
					next_state = i_nv_sig_ok ? ST_START : ST_DIAG;
				end
			end
			ST_START: begin
				if (i_entry_frame) begin
					next_state = ST_COMMAND;
				end else if (win_done && !first_pass) begin
					next_state = ST_NORMAL;
				end
			end
			ST_NORMAL:  next_state = ST_NORMAL;
			ST_COMMAND: next_state = ctrl[CTRL_CTEST] ? ST_CTEST : ST_COMMAND;
			ST_CTEST:   next_state = ctrl[CTRL_CTEST] ? ST_CTEST : ST_COMMAND;
			ST_DIAG:    next_state = ST_DIAG;
			default:    next_state = ST_DIAG;
		endcase
		// Any failure outside command handling and power-up enters diagnostic
		if ((|err_set) && state != ST_COMMAND && state != ST_CTEST
		    && state != ST_POWERUP) begin
			next_state = ST_DIAG;
		end
	end

	// State register
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state <= ST_POWERUP;
		end else begin
			state <= next_state;
		end
	end

	// -------------------------------------------------------------
	// Start window timer
	// -------------------------------------------------------------
	// Counts only while in start routine; saturates at the end
	always_ff @(posedge i_clk) begin
		if (i_srst || state != ST_START) begin
			win_cnt <= '0;
		end else if (!win_done) begin
			win_cnt <= win_cnt + 24'd1;
		end
	end

	// -------------------------------------------------------------
	// Measurement cycle stepping
	// -------------------------------------------------------------
	// Even phases are the eight fixed steps, odd phases the bridge
	always_ff @(posedge i_clk) begin
		if (i_srst || (state != ST_START && state != ST_NORMAL)) begin
			phase      <= '0;
			first_pass <= 1'b1;
			mux_start  <= 1'b0;
		end else begin
			mux_start <= 1'b0;
			if (i_step_done) begin
				phase     <= phase + 4'd1;
				mux_start <= 1'b1;
				if (phase == 4'hf) begin
					first_pass <= 1'b0;
				end
			end
		end
	end

	// Step code from phase; diagnostic steps never skipped
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_mux_step <= MX_BRIDGE_AZ;
		end else if (phase[0]) begin
			o_mux_step <= MX_BRIDGE;
		end else begin
			o_mux_step <= mux_step_t'({1'b0, phase[3:1]});
		end
	end

	// -------------------------------------------------------------
	// Error capture
	// -------------------------------------------------------------
	// Sensor faults count only when diagnostic processing enabled
	always_comb begin
		err_set        = '0;
		err_set.sig    = (state == ST_NVREAD) && i_nv_done && !i_nv_sig_ok;
		err_set.die    = (state == ST_START) && ctrl[CTRL_BDC_EN] && i_die_fail;
		err_set.sensor = (state == ST_NORMAL) && ctrl[CTRL_DIAG_EN] && i_sensor_fail;
		err_set.mem    = (state == ST_START || state == ST_NORMAL) && i_selftest_fail;
		err_set.wdog   = (wdog_cnt == 11'(WDOG_CYC));
		err_set.osc    = (osc_cnt == 9'(OSC_CHK_CYC));
	end

	// Sticky flags; a set in the clear cycle wins
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			err <= '0;
		end else begin
			err <= (err & ~err_clr) | err_set;
		end
	end

	// Watchdog: cleared by either math heartbeat or loop progress
	always_ff @(posedge i_clk) begin
		if (i_srst || (state != ST_START && state != ST_NORMAL)) begin
			wdog_cnt <= '0;
		end else if (i_calc_alive || i_step_done) begin
			wdog_cnt <= '0;
		end else if (wdog_cnt != 11'(WDOG_CYC)) begin
			wdog_cnt <= wdog_cnt + 11'd1;
		end
	end

	// Oscillator tick synchroniser and timeout
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			osc_s1  <= 1'b0;
			osc_s2  <= 1'b0;
			osc_s3  <= 1'b0;
			osc_cnt <= '0;
		end else begin
			osc_s1 <= i_osc_tick;
			osc_s2 <= osc_s1;
			osc_s3 <= osc_s2;
			if (osc_s2 != osc_s3) begin
				osc_cnt <= '0;
			end else if (osc_cnt != 9'(OSC_CHK_CYC)) begin
				osc_cnt <= osc_cnt + 9'd1;
			end
		end
	end

	// -------------------------------------------------------------
	// Output control
	// -------------------------------------------------------------
	// Registered output stage
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_state         <= ST_POWERUP;
			o_mux_start     <= 1'b0;
			o_drv_hiz       <= 1'b1;
			o_pwm_run       <= 1'b0;
			o_pwm_resistive <= 1'b0;
			o_lin_respond   <= 1'b0;
			o_high_invert   <= 1'b0;
			o_lin_err       <= '0;
			o_ctest         <= '0;
			o_lin_frame_ack <= 1'b0;
		end else begin
			o_state         <= state;
			o_mux_start     <= mux_start;
			// Tri-state except when an output actually drives
			o_drv_hiz       <= (state != ST_NORMAL && state != ST_DIAG);
			o_pwm_run       <= (state == ST_NORMAL) && (out_sel != OUT_LIN);
			o_pwm_resistive <= (state == ST_DIAG) && (out_sel != OUT_LIN);
			o_lin_respond   <= (state == ST_NORMAL || state == ST_DIAG)
			                   && (out_sel == OUT_LIN);
			o_high_invert   <= (out_sel == OUT_HIGH);
			o_lin_err       <= (out_sel == OUT_LIN) ? err : '0;
			o_ctest         <= (state == ST_CTEST) ? ctest : '0;
			o_lin_frame_ack <= i_lin_frame && (state == ST_NORMAL)
			                   && (out_sel == OUT_LIN);
		end
	end

	// -------------------------------------------------------------
	// AXI4-Lite write channel
	// -------------------------------------------------------------
	// Address and data taken in any order, response after both
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			aw_hold  <= 1'b0;
			w_hold   <= 1'b0;
			aw_addr  <= '0;
			w_data   <= '0;
			w_strb   <= '0;
			o_bvalid <= 1'b0;
			o_bresp  <= 2'b00;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_hold <= 1'b1;
				w_data <= i_wdata;
				w_strb <= i_wstrb;
			end
			if (wr_go) begin
				aw_hold  <= 1'b0;
				w_hold   <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp  <= (aw_addr == REG_CTRL || aw_addr == REG_ERR
				             || aw_addr == REG_CTEST || aw_addr == REG_STATUS)
				            ? 2'b00 : 2'b10;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	assign o_awready = !aw_hold && !o_bvalid;
	assign o_wready  = !w_hold && !o_bvalid;

	// Register writes; strobes honoured on low byte fields
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctrl  <= CTRL_RST;
			ctest <= '0;
		end else if (wr_go && w_strb[0]) begin
			if (aw_addr == REG_CTRL) begin
				ctrl <= {24'h00_0000, w_data[7:0]};
			end
			if (aw_addr == REG_CTEST) begin
				ctest <= ctest_t'(w_data[2:0]);
			end
		end
	end

	assign err_clr = (wr_go && w_strb[0] && aw_addr == REG_ERR) ? err_t'(w_data[5:0]) : '0;

	// -------------------------------------------------------------
	// AXI4-Lite read channel
	// -------------------------------------------------------------
	// One read at a time; data one cycle after address
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rvalid <= 1'b0;
			o_rdata  <= '0;
			o_rresp  <= 2'b00;
		end else if (i_arvalid && o_arready) begin
			o_rvalid <= 1'b1;
			o_rresp  <= 2'b00;
			unique case (i_araddr)
				REG_CTRL:   o_rdata <= ctrl;
				REG_STATUS: o_rdata <= {23'h0, first_pass, phase, 1'b0, state};
				REG_ERR:    o_rdata <= {26'h0, err};
				REG_CTEST:  o_rdata <= {29'h0, ctest};
				default: begin
					o_rdata <= '0;
					o_rresp <= 2'b10;
				end
			endcase
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
		end
	end

	assign o_arready = !o_rvalid;

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	sequence s_entry;
		state == ST_START && i_entry_frame;
	endsequence
	a_entry_cmd: assert property (@(posedge i_clk) disable iff (i_srst)
		s_entry |=> state == ST_COMMAND)
		else $error("entry frame did not enter command state");
	a_window_hiz: assert property (@(posedge i_clk) disable iff (i_srst)
		state == ST_START |=> o_drv_hiz)
		else $error("drivers active during start window");
	a_sig_fail: assert property (@(posedge i_clk) disable iff (i_srst)
		state == ST_NVREAD && i_nv_done && !i_nv_sig_ok |=> state == ST_DIAG)
		else $error("bad signature not diagnosed");
	a_normal_gate: assert property (@(posedge i_clk) disable iff (i_srst)
		state == ST_START && !(win_done && !first_pass) |=> state != ST_NORMAL)
		else $error("normal entered before window end");
	a_bridge_step: assert property (@(posedge i_clk) disable iff (i_srst)
		phase[0] |=> o_mux_step == MX_BRIDGE)
		else $error("bridge measurement missing");
	a_pwm_resist: assert property (@(posedge i_clk) disable iff (i_srst)
		state == ST_DIAG && out_sel != OUT_LIN |=> o_pwm_resistive && !o_pwm_run)
		else $error("pwm not resistive in diagnostic");
	a_wdog_trip: assert property (@(posedge i_clk) disable iff (i_srst)
		wdog_cnt == 11'(WDOG_CYC) && state inside {ST_START, ST_NORMAL} |=> state == ST_DIAG)
		else $error("watchdog expiry ignored");
	a_err_sticky: assert property (@(posedge i_clk) disable iff (i_srst)
		state inside {ST_START, ST_NORMAL} && i_selftest_fail |=> err.mem ##1 state == ST_DIAG)
		else $error("self test failure not kept");
endmodule // sensor_conditioning_sequencer

// >>> seq_far_end.sv
// Purpose: Far-side tester model for the sequencer
// Assumes: Frame decoding is done; the model hands over decoded pulses
// Notes:   Sends an entry frame only while the device drivers are tri-stated
`timescale 1ns/1ps
module seq_far_end (
	input  wire logic i_clk,
	input  wire logic i_send,  // Bench asks for an entry frame
	input  wire logic i_hiz,   // Device drivers tri-stated
	output logic      o_entry, // Decoded entry frame pulse
	output logic      o_tick   // Oscillator monitor tick
);
	logic sent = 1'b0; // Request already served

	// ----------------------------------------
	// Entry frame, one pulse per request
	// ----------------------------------------
	initial o_entry = 1'b0;
	always @(posedge i_clk) begin
		o_entry <= i_send && !sent && i_hiz;
		sent    <= i_send;
	end

	// Tick on its own period, unrelated to the clock
	initial begin
		o_tick = 1'b0;
		forever #7.3 o_tick = !o_tick;
	end
endmodule // seq_far_end

// >>> test_sensor_conditioning_sequencer.sv
// Purpose: Self-checking bench for the conditioning sequencer
// Assumes: Runs stay inside the start window, which is far too long to pass
// Notes:   Bus tasks hold each valid until its ready is sampled
`timescale 1ns/1ps
module test_sensor_conditioning_sequencer
	import seq_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic i_clk, i_srst = 1'b1, i_awvalid = 1'b0, i_wvalid = 1'b0, i_arvalid = 1'b0;
	logic i_bready = 1'b1, i_rready = 1'b1, i_nv_done = 1'b0, i_nv_sig_ok = 1'b0;
	logic i_step_done = 1'b0, i_die_fail = 1'b0, i_sensor_fail = 1'b0;
	logic i_selftest_fail = 1'b0, i_calc_alive = 1'b0, i_lin_frame = 1'b0, send = 1'b0;
	logic i_entry_frame, i_osc_tick, alive_en = 1'b1, o_awready, o_wready, o_bvalid;
	logic o_arready, o_rvalid, o_drv_hiz, o_mux_start, o_pwm_resistive;
	logic o_pwm_run, o_lin_respond, o_high_invert, o_lin_frame_ack;
	logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00, beat = 8'h00;
	logic [31:0] i_wdata = 32'h0, o_rdata;
	logic [3:0]  i_wstrb = 4'hf;
	logic [1:0]  o_bresp, o_rresp;
	sys_state_t  o_state;
	mux_step_t   o_mux_step;
	err_t        o_lin_err;
	ctest_t      o_ctest;
	int          failures = 0, total_checks = 0;

	sensor_conditioning_sequencer sensor_conditioning_sequencer_i (
		.i_clk, .i_srst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
		.o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
		.o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_nv_done, .i_nv_sig_ok, .i_step_done,
		.i_die_fail, .i_sensor_fail, .i_selftest_fail, .i_calc_alive, .i_osc_tick,
		.i_entry_frame, .i_lin_frame, .o_state, .o_mux_step, .o_mux_start, .o_drv_hiz,
		.o_pwm_run, .o_pwm_resistive, .o_lin_respond, .o_high_invert, .o_lin_err,
		.o_ctest, .o_lin_frame_ack
	);
	seq_far_end seq_far_end_i (.i_clk, .i_send(send), .i_hiz(o_drv_hiz),
		.o_entry(i_entry_frame), .o_tick(i_osc_tick));

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = !i_clk;
	end
	// Math heartbeat every 256 cycles, well inside the watchdog limit
	always @(posedge i_clk) begin
		beat         <= beat + 8'h01;
		i_calc_alive <= alive_en && (beat == 8'h3f);
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic lost();
		failures++;
		$display("BAD t=%0t wait ran out", $time);
		end_sim();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic wait_state(input sys_state_t s, input int lim);
		for (int n = 0; n < lim && o_state !== s; n++) cyc(1);
		if (o_state !== s) lost();
	endtask
	// Write: both channels offered together, each dropped when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		i_awaddr  <= a;
		i_wdata   <= d;
		i_awvalid <= 1'b1;
		i_wvalid  <= 1'b1;
		for (n = 0; n < 64; n++) begin
			cyc(1);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
			if (o_bvalid) break;
		end
		if (n == 64) lost();
		r = o_bresp;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		i_araddr  <= a;
		i_arvalid <= 1'b1;
		for (n = 0; n < 64; n++) begin
			cyc(1);
			if (o_arready) i_arvalid <= 1'b0;
			if (o_rvalid) break;
		end
		if (n == 64) lost();
		d = o_rdata;
		r = o_rresp;
	endtask
	task automatic do_reset();
		i_die_fail      <= 1'b0;
		i_selftest_fail <= 1'b0;
		alive_en        <= 1'b1;
		i_srst          <= 1'b1;
		cyc(8);
		chk(o_state, ST_POWERUP);
		chk(o_drv_hiz, 1'b1);
		i_srst <= 1'b0;
		wait_state(ST_NVREAD, 4);
	endtask
	task automatic to_start(input logic ok);
		i_nv_sig_ok <= ok;
		i_nv_done   <= 1'b1;
		cyc(1);
		i_nv_done <= 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_regs();
		logic [31:0] d;
		logic [1:0]  r;
		do_reset();
		axr(REG_CTRL, d, r);
		chk(d, CTRL_RST);
		chk(r, 2'b00);
		axw(REG_CTRL, 32'h24, r);
		chk(r, 2'b00);
		axr(REG_CTRL, d, r);
		chk(d, 32'h24);
		axw(8'h10, 32'hff, r);
		chk(r, 2'b10);
		axr(8'h10, d, r);
		chk(r, 2'b10);
		chk(d, 32'h0);
		axr(REG_STATUS, d, r);
		chk(d, 32'h101);
		axw(REG_CTRL, 32'h0, r);
	endtask
	// Full first pass with diagnostics off, then command entry and test state
	task automatic s_cycle();
		int n;
		logic [1:0] r;
		to_start(1'b1);
		wait_state(ST_START, 4);
		chk(o_drv_hiz, 1'b1);
		chk(o_mux_step, MX_BRIDGE_AZ);
		for (int p = 1; p <= 16; p++) begin
			i_step_done <= 1'b1;
			cyc(1);
			i_step_done <= 1'b0;
			for (n = 0; n < 6 && o_mux_start !== 1'b1; n++) cyc(1);
			if (o_mux_start !== 1'b1) lost();
			chk(o_mux_step, (p % 2) ? MX_BRIDGE : 4'((p / 2) % 8));
		end
		chk(o_state, ST_START);
		// A LIN frame inside the window is not answered as in normal state
		i_lin_frame <= 1'b1;
		cyc(1);
		i_lin_frame <= 1'b0;
		cyc(1);
		chk(o_lin_frame_ack, 1'b0);
		chk(o_lin_respond, 1'b0);
		chk(o_pwm_run, 1'b0);
		send <= 1'b1;
		wait_state(ST_COMMAND, 6);
		send <= 1'b0;
		chk(o_drv_hiz, 1'b1);
		i_selftest_fail <= 1'b1;
		cyc(4);
		chk(o_state, ST_COMMAND);
		i_selftest_fail <= 1'b0;
		axw(REG_CTRL, 32'h10, r);
		wait_state(ST_CTEST, 6);
		axw(REG_CTEST, 32'h5, r);
		cyc(3);
		chk(o_ctest, 3'b101);
		axw(REG_CTRL, 32'h0, r);
		wait_state(ST_COMMAND, 6);
		chk(o_ctest, 3'b000);
	endtask
	// Signature, broken die, self test with high-side PWM, watchdog
	task automatic s_faults();
		logic [1:0]  r;
		logic [31:0] d;
		logic [31:0] cfg [4] = '{32'h0, 32'h8, 32'h1, 32'h0};
		logic [5:0]  exp [4] = '{6'h01, 6'h02, 6'h08, 6'h10};
		for (int k = 0; k < 4; k++) begin
			do_reset();
			axw(REG_CTRL, cfg[k], r);
			to_start(k != 0);
			i_die_fail      <= (k == 1);
			i_selftest_fail <= (k == 2);
			alive_en        <= (k != 3);
			wait_state(ST_DIAG, 3000);
			chk(o_drv_hiz, 1'b0);
			chk(o_lin_err, (k == 2) ? 6'h00 : exp[k]);
			chk(o_pwm_resistive, k == 2);
			chk(o_pwm_run, 1'b0);
			chk(o_lin_respond, k != 2);
			chk(o_high_invert, k == 2);
			// Sticky flags read back, then cleared by writing ones
			axr(REG_ERR, d, r);
			chk(d, {26'h0, exp[k]});
			axw(REG_ERR, 32'h3f, r);
			axr(REG_ERR, d, r);
			chk(d, 32'h0);
		end
	endtask

	initial begin
		cyc(1);
		s_regs();
		s_cycle();
		s_faults();
		end_sim();
	end
endmodule // test_sensor_conditioning_sequencer
